/* File: hw/dsg_deep_sleep_gate.sv */
// Deep-sleep clock gate register with peripheral clock enables and bus fault check
//
// How it works
// - Each enable bit drives one peripheral clock enable; clear stops that unit.
// - Access to a peripheral whose gated clock is off returns a bus fault.
// - Gate bits reset to zero unless noted; software enables needed units.
// - Whole register resets to 0x00000040, so the hibernation gate starts set.
// - Bit 24 is the read/write gate for the CAN unit clock.
// - Bit 20 gates the PWM clock; PWM accesses fault while unclocked.
// - Bit 16 gates the ADC clock; ADC accesses fault while unclocked.
// - Bits 9:8 select ADC rate: 3=1M, 2=500K, 1=250K, 0=125K.
// - A rate above the permitted maximum is clamped, never honoured.
// - Bit 6 is the read/write gate for the hibernation clock.
// - Bit 3 gates the watchdog clock; watchdog accesses fault while unclocked.
// - Reserved bits are read-only and read as zero.
// - These gates apply in deep sleep; other modes use the run or sleep gates.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "dsg_consts.svh"

module dsg_deep_sleep_gate #(
   parameter logic [1:0] MAX_ADC_RATE = `DSG_RATE_MAX
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,

   // Register port
   input wire dsg_pkg::dsg_reg_req_t regReq,
   output logic [31:0] regRdData_q,

   // Power mode and gates of the other modes
   input wire logic deepSleep,
   input wire logic [4:0] otherModeGates,

   // Peripheral access check
   input wire dsg_pkg::dsg_periph_req_t periphReq,
   output logic busFault_q,
   output logic accessDone_q,

   // Clock enables and ADC rate
   output logic [4:0] unitClkEn_q,
   output dsg_pkg::dsg_rate_t adcRate_q
);
   import dsg_pkg::*;

   logic [4:0] gates_q;
   logic [4:0] gates_d;
   logic [1:0] rateReq;
   dsg_rate_t rate_d;
   logic [31:0] readWord;
   logic hit;
   logic wrHit;
   logic [4:0] unitClkEn_d;
   logic unitOn;

   assign hit = (regReq.addr == `DSG_REG_OFFSET);
   assign wrHit = regReq.wrStrobe && hit;

   // Gate bits taken from the write word
   always_comb begin
      gates_d = gates_q;
      if (wrHit) begin
         gates_d[`DSG_UNIT_CAN] = regReq.wrData[`DSG_BIT_CAN];
         gates_d[`DSG_UNIT_PWM] = regReq.wrData[`DSG_BIT_PWM];
         gates_d[`DSG_UNIT_ADC] = regReq.wrData[`DSG_BIT_ADC];
         gates_d[`DSG_UNIT_HIBERNATION] = regReq.wrData[`DSG_BIT_HIBERNATION];
         gates_d[`DSG_UNIT_WATCHDOG] = regReq.wrData[`DSG_BIT_WATCHDOG];
      end
   end

   // Rate field, clamped to the permitted maximum
   always_comb begin
      rateReq = regReq.wrData[`DSG_RATE_HI:`DSG_RATE_LO];
      rate_d = adcRate_q;
      if (wrHit) begin
         if (rateReq > MAX_ADC_RATE) begin
            rate_d = dsg_rate_t'(MAX_ADC_RATE);
         end else begin
            rate_d = dsg_rate_t'(rateReq);
         end
      end
   end

   // Stored fields; reserved bits have no storage
   always_ff @(posedge clock) begin
      if (rst) begin
         gates_q <= `DSG_GATES_RESET;
      end else begin
         gates_q <= gates_d;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         adcRate_q <= dsg_rate_t'(`DSG_RATE_RESET);
      end else begin
         adcRate_q <= rate_d;
      end
   end

   // Read word assembled from the fields
   always_comb begin
      readWord = `DSG_ZERO_WORD;
      readWord[`DSG_BIT_CAN] = gates_q[`DSG_UNIT_CAN];
      readWord[`DSG_BIT_PWM] = gates_q[`DSG_UNIT_PWM];
      readWord[`DSG_BIT_ADC] = gates_q[`DSG_UNIT_ADC];
      readWord[`DSG_BIT_HIBERNATION] = gates_q[`DSG_UNIT_HIBERNATION];
      readWord[`DSG_BIT_WATCHDOG] = gates_q[`DSG_UNIT_WATCHDOG];
      readWord[`DSG_RATE_HI:`DSG_RATE_LO] = adcRate_q;
   end

   // Read data stands for one cycle only; unmapped reads give zero
   always_ff @(posedge clock) begin
      if (rst) begin
         regRdData_q <= `DSG_ZERO_WORD;
      end else if (regReq.rdStrobe && hit) begin
         regRdData_q <= readWord;
      end else begin
         regRdData_q <= `DSG_ZERO_WORD;
      end
   end

   // Mode select of each unit clock
   genvar u;
   generate
      for (u = 0; u < `DSG_UNITS; u = u + 1) begin : g_unit
         assign unitClkEn_d[u] = deepSleep ? gates_q[u] : otherModeGates[u];
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (rst) begin
         unitClkEn_q <= `DSG_GATES_RESET;
      end else begin
         unitClkEn_q <= unitClkEn_d;
      end
   end

   // Access check against the clock as it stands now
   always_comb begin
      unitOn = 1'b0;
      if (periphReq.unit < 3'(`DSG_UNITS)) begin
         unitOn = unitClkEn_q[periphReq.unit];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         busFault_q <= 1'b0;
      end else begin
         busFault_q <= periphReq.valid && !unitOn;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         accessDone_q <= 1'b0;
      end else begin
         accessDone_q <= periphReq.valid && unitOn;
      end
   end

   // Checks

   a_reset_value: assert property (
      @(posedge clock) rst |=> (readWord == `DSG_RESET_VALUE)
   ) else $error("register did not come out of reset with its reset word");

   a_reset_gates: assert property (
      @(posedge clock) rst |=>
         (unitClkEn_q == `DSG_GATES_RESET) && !busFault_q && !accessDone_q
   ) else $error("outputs wrong after reset");

   a_reserved_zero: assert property (
      @(posedge clock) disable iff (rst)
      (regRdData_q & ~`DSG_RW_MASK) == `DSG_ZERO_WORD
   ) else $error("reserved bit read as one");

   a_write_readback: assert property (
      @(posedge clock) disable iff (rst)
      (wrHit && regReq.wrData[`DSG_RATE_HI:`DSG_RATE_LO] <= MAX_ADC_RATE)
      ##1 (regReq.rdStrobe && hit) |=>
         regRdData_q == ($past(regReq.wrData, 2) & `DSG_RW_MASK)
   ) else $error("read did not return written fields");

   a_read_one_cycle: assert property (
      @(posedge clock) disable iff (rst)
      !regReq.rdStrobe |=> regRdData_q == `DSG_ZERO_WORD
   ) else $error("read data stood without a read");

   a_rate_clamp: assert property (
      @(posedge clock) disable iff (rst)
      wrHit && (regReq.wrData[`DSG_RATE_HI:`DSG_RATE_LO] > MAX_ADC_RATE)
      |=> adcRate_q == dsg_rate_t'(MAX_ADC_RATE)
   ) else $error("rate above maximum was honoured");

   a_rate_write: assert property (
      @(posedge clock) disable iff (rst)
      wrHit && (regReq.wrData[`DSG_RATE_HI:`DSG_RATE_LO] <= MAX_ADC_RATE)
      |=> adcRate_q == $past(regReq.wrData[`DSG_RATE_HI:`DSG_RATE_LO])
   ) else $error("rate field not stored");

   a_pwm_gate: assert property (
      @(posedge clock) disable iff (rst)
      wrHit && deepSleep ##1 deepSleep |=>
         unitClkEn_q[`DSG_UNIT_PWM] == $past(regReq.wrData[`DSG_BIT_PWM], 2)
   ) else $error("PWM clock enable does not follow its gate bit");

   a_watchdog_gate: assert property (
      @(posedge clock) disable iff (rst)
      wrHit && deepSleep ##1 deepSleep |=>
         unitClkEn_q[`DSG_UNIT_WATCHDOG] == $past(regReq.wrData[`DSG_BIT_WATCHDOG], 2)
   ) else $error("watchdog clock enable does not follow its gate bit");

   a_other_mode: assert property (
      @(posedge clock) disable iff (rst)
      !deepSleep |=> unitClkEn_q == $past(otherModeGates)
   ) else $error("outside deep sleep the other mode gates were ignored");

   a_fault_off: assert property (
      @(posedge clock) disable iff (rst)
      periphReq.valid && (periphReq.unit < 3'(`DSG_UNITS))
      && !unitClkEn_q[periphReq.unit] |=> busFault_q && !accessDone_q
   ) else $error("access to unclocked unit did not fault");

   a_pass_on: assert property (
      @(posedge clock) disable iff (rst)
      periphReq.valid && (periphReq.unit < 3'(`DSG_UNITS))
      && unitClkEn_q[periphReq.unit] |=> !busFault_q && accessDone_q
   ) else $error("access to clocked unit did not complete");

   a_idle_quiet: assert property (
      @(posedge clock) disable iff (rst)
      !periphReq.valid |=> !busFault_q && !accessDone_q
   ) else $error("answer without an access");

   // Register path checks
   a_reset_rate: assert property (
      @(posedge clock) rst |=>
         (adcRate_q == dsg_rate_t'(`DSG_RATE_RESET)) && (regRdData_q == `DSG_ZERO_WORD)
   ) else $error("rate or read data wrong after reset");

   a_field_map: assert property (
      @(posedge clock) disable iff (rst)
      (readWord & ~`DSG_RW_MASK) == `DSG_ZERO_WORD
   ) else $error("reserved bit held a value");

   a_read_data: assert property (
      @(posedge clock) disable iff (rst)
      regReq.rdStrobe && hit |=> regRdData_q == $past(readWord)
   ) else $error("read did not return the stored word");

   a_unmapped_read: assert property (
      @(posedge clock) disable iff (rst)
      regReq.rdStrobe && !hit |=> regRdData_q == `DSG_ZERO_WORD
   ) else $error("unmapped read returned a value");

   a_write_no_read: assert property (
      @(posedge clock) disable iff (rst)
      regReq.wrStrobe |=> regRdData_q == `DSG_ZERO_WORD
   ) else $error("read data appeared after a write");

   a_unmapped_write: assert property (
      @(posedge clock) disable iff (rst)
      regReq.wrStrobe && !hit |=> readWord == $past(readWord)
   ) else $error("unmapped write changed the register");

   a_gates_hold: assert property (
      @(posedge clock) disable iff (rst)
      !wrHit |=> gates_q == $past(gates_q)
   ) else $error("gate bits changed without a write");

   a_rate_hold: assert property (
      @(posedge clock) disable iff (rst)
      !wrHit |=> adcRate_q == $past(adcRate_q)
   ) else $error("rate changed without a write");

   a_rate_range: assert property (
      @(posedge clock) disable iff (rst)
      adcRate_q <= MAX_ADC_RATE
   ) else $error("rate above the permitted maximum");

   // Clock enable checks
   a_can_gate: assert property (
      @(posedge clock) disable iff (rst)
      wrHit && deepSleep ##1 deepSleep |=>
         unitClkEn_q[`DSG_UNIT_CAN] == $past(regReq.wrData[`DSG_BIT_CAN], 2)
   ) else $error("CAN clock enable does not follow its gate bit");

   a_adc_gate: assert property (
      @(posedge clock) disable iff (rst)
      wrHit && deepSleep ##1 deepSleep |=>
         unitClkEn_q[`DSG_UNIT_ADC] == $past(regReq.wrData[`DSG_BIT_ADC], 2)
   ) else $error("ADC clock enable does not follow its gate bit");

   a_hibernation_gate: assert property (
      @(posedge clock) disable iff (rst)
      wrHit && deepSleep ##1 deepSleep |=>
         unitClkEn_q[`DSG_UNIT_HIBERNATION] == $past(regReq.wrData[`DSG_BIT_HIBERNATION], 2)
   ) else $error("hibernation clock enable does not follow its gate bit");

   a_enable_deep: assert property (
      @(posedge clock) disable iff (rst)
      deepSleep |=> unitClkEn_q == $past(gates_q)
   ) else $error("deep sleep enables do not follow the gate bits");

   // Access answer checks
   a_fault_range: assert property (
      @(posedge clock) disable iff (rst)
      periphReq.valid && (periphReq.unit >= 3'(`DSG_UNITS)) |=> busFault_q
   ) else $error("access to an unknown unit did not fault");

   a_done_range: assert property (
      @(posedge clock) disable iff (rst)
      periphReq.valid && (periphReq.unit >= 3'(`DSG_UNITS)) |=> !accessDone_q
   ) else $error("access to an unknown unit completed");

   a_answer_onehot: assert property (
      @(posedge clock) disable iff (rst)
      !(busFault_q && accessDone_q)
   ) else $error("fault and completion at once");

   a_fault_pwm: assert property (
      @(posedge clock) disable iff (rst)
      periphReq.valid && (periphReq.unit == 3'(`DSG_UNIT_PWM))
      && !unitClkEn_q[`DSG_UNIT_PWM] |=> busFault_q
   ) else $error("PWM access while unclocked did not fault");

   a_fault_adc: assert property (
      @(posedge clock) disable iff (rst)
      periphReq.valid && (periphReq.unit == 3'(`DSG_UNIT_ADC))
      && !unitClkEn_q[`DSG_UNIT_ADC] |=> busFault_q
   ) else $error("ADC access while unclocked did not fault");

   a_fault_watchdog: assert property (
      @(posedge clock) disable iff (rst)
      periphReq.valid && (periphReq.unit == 3'(`DSG_UNIT_WATCHDOG))
      && !unitClkEn_q[`DSG_UNIT_WATCHDOG] |=> busFault_q
   ) else $error("watchdog access while unclocked did not fault");

endmodule : dsg_deep_sleep_gate

`default_nettype wire

/* File: hw/dsg_consts.svh */
// Constants for the deep-sleep clock gate register block
`ifndef DSG_CONSTS_SVH
`define DSG_CONSTS_SVH

// Register map
`define DSG_ADDR_W 12
`define DSG_REG_OFFSET 12'h120
`define DSG_DATA_W 32
`define DSG_RESET_VALUE 32'h00000040
`define DSG_RW_MASK 32'h01110348
`define DSG_ZERO_WORD 32'h00000000

// Field positions
`define DSG_BIT_CAN 24
`define DSG_BIT_PWM 20
`define DSG_BIT_ADC 16
`define DSG_BIT_HIBERNATION 6
`define DSG_BIT_WATCHDOG 3
`define DSG_RATE_HI 9
`define DSG_RATE_LO 8

// Unit indices within the gate vector
`define DSG_UNITS 5
`define DSG_UNIT_CAN 0
`define DSG_UNIT_PWM 1
`define DSG_UNIT_ADC 2
`define DSG_UNIT_HIBERNATION 3
`define DSG_UNIT_WATCHDOG 4

// Reset values of the fields and the default ADC rate ceiling
`define DSG_GATES_RESET 5'h08
`define DSG_RATE_RESET 2'h0
`define DSG_RATE_MAX 2'h3

`endif

/* File: hw/dsg_pkg.sv */
// Types shared by the deep-sleep clock gate block
package dsg_pkg;

   typedef enum logic [1:0] {
      DSG_RATE_125K = 2'h0,
      DSG_RATE_250K = 2'h1,
      DSG_RATE_500K = 2'h2,
      DSG_RATE_1M = 2'h3
   } dsg_rate_t;

   // Register port request from software
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wrData;
      logic wrStrobe;
      logic rdStrobe;
   } dsg_reg_req_t;

   // Access attempt towards one gated peripheral
   typedef struct packed {
      logic valid;
      logic [2:0] unit;
   } dsg_periph_req_t;

endpackage : dsg_pkg

/* File: test/dsg_deep_sleep_gate_tb.sv */
// Self-checking bench for the deep-sleep clock gate register block
`timescale 1ns/100ps
`default_nettype none
`include "dsg_consts.svh"
`define CHK(a, b, m) begin testsRun++; if ((a) !== (b)) begin nFail++; \
   $display("CHECK FAILED t=%0t %s", $time, m); end end

module dsg_deep_sleep_gate_tb;
   import dsg_pkg::*;
   // Below the 1M ceiling so that clamping can be seen
   localparam logic [1:0] MaxRate = 2'h2;
   localparam logic [11:0] Reg = `DSG_REG_OFFSET;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic deepSleep = 1'b1;
   logic [4:0] otherModeGates = 5'h15;
   dsg_reg_req_t regReq = '0;
   dsg_periph_req_t periphReq = '0;
   logic [31:0] regRdData_q;
   logic busFault_q;
   logic accessDone_q;
   logic [4:0] unitClkEn_q;
   dsg_rate_t adcRate_q;
   int nFail = 0;
   int testsRun = 0;
   int bitPos [5] = '{`DSG_BIT_CAN, `DSG_BIT_PWM, `DSG_BIT_ADC,
      `DSG_BIT_HIBERNATION, `DSG_BIT_WATCHDOG};

   dsg_deep_sleep_gate #(.MAX_ADC_RATE(MaxRate)) dut (
      .clock(clock), .rst(rst), .regReq(regReq), .regRdData_q(regRdData_q),
      .deepSleep(deepSleep), .otherModeGates(otherModeGates), .periphReq(periphReq),
      .busFault_q(busFault_q), .accessDone_q(accessDone_q), .unitClkEn_q(unitClkEn_q),
      .adcRate_q(adcRate_q));

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      regReq <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      regReq.wrStrobe <= 1'b0;
   endtask : wr

   // Read data stands one cycle only, then falls back to zero
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clock);
      regReq <= '{a, 32'h00000000, 1'b0, 1'b1};
      @(posedge clock);
      regReq.rdStrobe <= 1'b0;
      #1;
      `CHK(regRdData_q, exp, "read data")
      @(posedge clock);
      #1;
      `CHK(regRdData_q, 32'h00000000, "read data after its cycle")
   endtask : rd

   task automatic probe(input logic [2:0] u, input logic fault);
      @(posedge clock);
      periphReq <= '{1'b1, u};
      @(posedge clock);
      periphReq.valid <= 1'b0;
      #1;
      `CHK(busFault_q, fault, "fault flag")
      `CHK(accessDone_q, ~fault, "done flag")
   endtask : probe

   task automatic t_reset();
      rd(Reg, 32'h00000040);
      `CHK(unitClkEn_q, 5'h08, "enables after reset")
      `CHK(adcRate_q, DSG_RATE_125K, "rate after reset")
      probe(3'h3, 1'b0);
      probe(3'h4, 1'b1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_fields();
      wr(Reg, 32'hffffffff);
      rd(Reg, 32'h01110048 | {22'h0, MaxRate, 8'h00});
      `CHK(adcRate_q, MaxRate, "clamped rate")
      wr(12'h124, 32'h00000000);
      rd(Reg, 32'h01110048 | {22'h0, MaxRate, 8'h00});
      rd(12'h124, 32'h00000000);
      $display("test fields done");
   endtask : t_fields

   task automatic t_rates();
      for (int r = 0; r < 4; r++) begin
         wr(Reg, {22'h0, r[1:0], 8'h00});
         rd(Reg, {22'h0, (r[1:0] > MaxRate) ? MaxRate : r[1:0], 8'h00});
         `CHK(adcRate_q, (r[1:0] > MaxRate) ? MaxRate : r[1:0], "rate")
      end
      $display("test rates done");
   endtask : t_rates

   task automatic t_units();
      for (int u = 0; u < 5; u++) begin
         wr(Reg, 32'h00000001 << bitPos[u]);
         @(posedge clock);
         #1;
         `CHK(unitClkEn_q, 5'(1 << u), "single enable")
         probe(3'(u), 1'b0);
         probe(3'((u + 1) % 5), 1'b1);
      end
      probe(3'h5, 1'b1);
      $display("test units done");
   endtask : t_units

   task automatic t_modes();
      @(posedge clock);
      deepSleep <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      `CHK(unitClkEn_q, otherModeGates, "other mode gates")
      probe(3'h2, 1'b0);
      probe(3'h1, 1'b1);
      @(posedge clock);
      otherModeGates <= 5'h0a;
      repeat (2) @(posedge clock);
      #1;
      `CHK(unitClkEn_q, 5'h0a, "second set of other mode gates")
      probe(3'h3, 1'b0);
      probe(3'h0, 1'b1);
      @(posedge clock);
      deepSleep <= 1'b1;
      $display("test modes done");
   endtask : t_modes

   // Write then read with no gap between the strobes
   task automatic t_burst();
      @(posedge clock);
      regReq <= '{Reg, 32'h00100008, 1'b1, 1'b0};
      @(posedge clock);
      regReq <= '{Reg, 32'h00000000, 1'b0, 1'b1};
      @(posedge clock);
      regReq.rdStrobe <= 1'b0;
      #1;
      `CHK(regRdData_q, 32'h00100008, "read right after write")
      @(posedge clock);
      #1;
      `CHK(regRdData_q, 32'h00000000, "burst read data after its cycle")
      `CHK(unitClkEn_q, 5'h12, "enables after burst")
      $display("test burst done");
   endtask : t_burst

   // Reset again in mid-run after the fields were changed
   task automatic t_rerun();
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(Reg, 32'h00000040);
      `CHK(unitClkEn_q, 5'h08, "enables after second reset")
      `CHK(adcRate_q, DSG_RATE_125K, "rate after second reset")
      $display("test rerun done");
   endtask : t_rerun

   task automatic summarize();
      $display("checks %0d mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   initial begin
      #200000;
      nFail++;
      summarize();
   end

   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_fields();
      t_rates();
      t_units();
      t_burst();
      t_modes();
      t_rerun();
      summarize();
   end
endmodule : dsg_deep_sleep_gate_tb
`default_nettype wire
